// ===== hw/gmt_message_transfer.sv
// Bus message transfer engine: listener receive, controller send, APB registers.
`timescale 1ns/1ps
module gmt_message_transfer import gmt_pkg::*; #(
   parameter int DEPTH = 64,
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [GMT_PAW-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic listener_addressed_in,
   input wire logic active_controller_in,
   input wire logic gb_rx_valid_in,
   input wire logic [7:0] gb_rx_data_in,
   input wire logic gb_rx_eoi_in,
   output logic gb_rx_ready_out,
   output logic gb_tx_valid_out,
   output logic [7:0] gb_tx_data_out,
   output logic gb_tx_eoi_out,
   output logic gb_tx_atn_out,
   input wire logic gb_tx_ready_in,
   output logic busy_out,
   output logic irq_out
);
   localparam int MAW = $clog2(DEPTH);

   gmt_state_t state; // Engine state.
   logic [31:0] mem [DEPTH]; // Host storage for received and sent bytes.
   logic eoi_only; // Alternate receive mode.
   logic [2:0] rx_term; // Receive terminator control byte.
   logic [7:0] tx_addr; // Send address byte.
   logic [15:0] maxlen; // Receive limit, also the send length.
   logic [15:0] rx_count; // Bytes stored so far.
   logic [15:0] tx_idx; // Next data byte to send.
   logic term_idx; // Which byte of the output sequence.
   logic [7:0] rx_status; // Receive status byte.
   logic [7:0] tx_status; // Send status byte.
   logic [31:0] in_term; // Four input terminator characters.
   logic [16:0] out_term [4]; // Four output terminator sequences.
   logic [23:0] timeout; // Timeout interval in cycles.
   logic [23:0] stall_cnt; // Cycles since the last handshake.
   logic [4:0] own_addr; // This interface's bus address.
   logic [1:0] int_status; // Sticky event bits.
   logic [1:0] int_mask; // Interrupt enables.
   logic [31:0] rd_latch; // Read data caught in the setup phase.
   logic setup, acc_wr, acc_rd, mem_hit, reg_hit;
   logic start_rx, start_tx, rx_take, tx_take, term_hit, expired, done_rx, done_tx;
   logic [7:0] term_char, tx_byte;
   logic [16:0] seq;
   logic [31:0] next_rd;

   // Bus phase decode; the slave never inserts wait states.
   assign setup = psel_in && !penable_in;
   assign acc_wr = psel_in && penable_in && pwrite_in;
   assign acc_rd = psel_in && penable_in && !pwrite_in;
   assign mem_hit = (paddr_in[11:8] == MEM_PAGE) && (32'(paddr_in[7:2]) < DEPTH);
   assign reg_hit = (paddr_in[11:8] == 4'h0) && (paddr_in[7:0] <= OFF_INT_MASK[7:0]) &&
                    (paddr_in[1:0] == 2'h0);
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !(mem_hit || reg_hit);
   assign prdata_out = rd_latch;

   // Start pulses come from control writes and only act in idle.
   assign start_rx = acc_wr && reg_hit && paddr_in == OFF_CTRL && pwdata_in[CTRL_START_RX];
   assign start_tx = acc_wr && reg_hit && paddr_in == OFF_CTRL && pwdata_in[CTRL_START_TX];

   // Selected input terminator; a match only counts when enabled and not in EOI mode.
   assign term_char = in_term[{rx_term[1:0], 3'b000} +: 8];
   assign term_hit = !eoi_only && rx_term[TERM_EN_BIT] && gb_rx_data_in == term_char;

   // Receive ready drops once the limit is reached, so nothing past it is stored.
   assign gb_rx_ready_out = (state == ST_RX) && (rx_count != maxlen);
   assign rx_take = gb_rx_ready_out && gb_rx_valid_in;
   assign tx_take = gb_tx_valid_out && gb_tx_ready_in;
   assign expired = (state != ST_IDLE) && (stall_cnt >= timeout);
   assign busy_out = (state != ST_IDLE);

   // Outgoing sequence and data byte for the current position.
   assign seq = out_term[tx_addr[7:6]];
   assign tx_byte = mem[tx_idx[MAW+1:2]][{tx_idx[1:0], 3'b000} +: 8];

   // Completion events for the interrupt logic.
   assign done_rx = (state == ST_RX) && (expired || (rx_count == maxlen) ||
                    (rx_take && (term_hit || gb_rx_eoi_in)));
   assign done_tx = (state == ST_TERM) && (expired || (tx_take && gb_tx_eoi_out));

   // Read mux; unused status positions are tied to zero by the status registers.
   always_comb begin
      next_rd = 32'h00000000;
      if (mem_hit) begin
         next_rd = mem[paddr_in[MAW+1:2]];
      end else begin
         unique case (paddr_in)
            OFF_CTRL: next_rd = {29'h0, eoi_only, 1'b0, busy_out};
            OFF_RX_TERM: next_rd = {29'h0, rx_term};
            OFF_TX_ADDR: next_rd = {24'h0, tx_addr};
            OFF_MAXLEN: next_rd = {16'h0, maxlen};
            OFF_RX_COUNT: next_rd = {16'h0, rx_count};
            OFF_RX_STATUS: next_rd = {24'h0, rx_status};
            OFF_TX_STATUS: next_rd = {24'h0, tx_status};
            OFF_IN_TERM: next_rd = in_term;
            OFF_OUT_TERM0: next_rd = {15'h0, out_term[0]};
            OFF_OUT_TERM1: next_rd = {15'h0, out_term[1]};
            OFF_OUT_TERM2: next_rd = {15'h0, out_term[2]};
            OFF_OUT_TERM3: next_rd = {15'h0, out_term[3]};
            OFF_TIMEOUT: next_rd = {8'h0, timeout};
            OFF_OWN_ADDR: next_rd = {27'h0, own_addr};
            OFF_INT_STATUS: next_rd = {30'h0, int_status};
            OFF_INT_MASK: next_rd = {30'h0, int_mask};
            default: next_rd = 32'h00000000;
         endcase
      end
   end

   // Read data is caught at the setup edge so it is a flop during the access phase.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rd_latch <= 32'h00000000;
      end else if (setup && !pwrite_in) begin
         rd_latch <= next_rd;
      end
   end

   // Software configuration registers; writes to busy-sensitive fields are allowed
   // at any time, so software must not change them while an operation runs.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         eoi_only <= 1'b0;
         rx_term <= 3'h0;
         tx_addr <= 8'h00;
         maxlen <= 16'h0000;
         in_term <= IN_TERM_RESET;
         out_term[0] <= OUT_TERM0_RESET;
         out_term[1] <= OUT_TERM1_RESET;
         out_term[2] <= OUT_TERM2_RESET;
         out_term[3] <= OUT_TERM3_RESET;
         timeout <= 24'(TIMEOUT_CYCLES);
         own_addr <= 5'h00;
         int_mask <= 2'h0;
      end else if (acc_wr && reg_hit) begin
         unique case (paddr_in)
            OFF_CTRL: eoi_only <= pwdata_in[CTRL_EOI_ONLY];
            OFF_RX_TERM: rx_term <= pwdata_in[2:0];
            OFF_TX_ADDR: tx_addr <= pwdata_in[7:0];
            OFF_MAXLEN: maxlen <= pwdata_in[15:0];
            OFF_IN_TERM: in_term <= pwdata_in;
            OFF_OUT_TERM0: out_term[0] <= pwdata_in[16:0];
            OFF_OUT_TERM1: out_term[1] <= pwdata_in[16:0];
            OFF_OUT_TERM2: out_term[2] <= pwdata_in[16:0];
            OFF_OUT_TERM3: out_term[3] <= pwdata_in[16:0];
            OFF_TIMEOUT: timeout <= pwdata_in[23:0];
            OFF_OWN_ADDR: own_addr <= pwdata_in[4:0];
            OFF_INT_MASK: int_mask <= pwdata_in[1:0];
            default: ;
         endcase
      end
   end

   // Storage: the receiver packs bytes in arrival order, lowest lane first. The bus may
   // only write while idle, which avoids two writers fighting over one word.
   always_ff @(posedge clock_in) begin
      if (rx_take && !term_hit) begin
         mem[rx_count[MAW+1:2]][{rx_count[1:0], 3'b000} +: 8] <= gb_rx_data_in;
      end else if (acc_wr && mem_hit && state == ST_IDLE) begin
         mem[paddr_in[MAW+1:2]] <= pwdata_in;
      end
   end

   // Handshake watchdog: restarts on every byte moved and at each new operation.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || state == ST_IDLE || rx_take || tx_take) begin
         stall_cnt <= 24'h000000;
      end else begin
         stall_cnt <= stall_cnt + 24'h000001;
      end
   end

   // Main sequencer for both receive and send.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         rx_count <= 16'h0000;
         tx_idx <= 16'h0000;
         term_idx <= 1'b0;
         rx_status <= 8'h00;
         tx_status <= 8'h00;
         gb_tx_valid_out <= 1'b0;
         gb_tx_data_out <= 8'h00;
         gb_tx_eoi_out <= 1'b0;
         gb_tx_atn_out <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_rx) begin
                  rx_count <= 16'h0000;
                  rx_status <= 8'h00;
                  if (!listener_addressed_in) begin
                     rx_status[ST_NOT_LISTENER] <= 1'b1;
                  end else begin
                     state <= ST_RX;
                  end
               end else if (start_tx) begin
                  tx_status <= 8'h00;
                  tx_idx <= 16'h0000;
                  term_idx <= 1'b0;
                  if (!active_controller_in) begin
                     tx_status[ST_NOT_CONTROLLER] <= 1'b1;
                  end else if (tx_addr[4:0] > ADDR_MAX || tx_addr[5]) begin
                     tx_status[ST_BAD_ADDR] <= 1'b1;
                  end else begin
                     state <= ST_LSN;
                  end
               end
            end
            ST_RX: begin
               if (expired) begin
                  rx_status[ST_TIMEOUT] <= 1'b1;
                  state <= ST_IDLE;
               end else if (rx_count == maxlen) begin
                  state <= ST_IDLE;
               end else if (rx_take) begin
                  if (term_hit) begin
                     rx_status[ST_END_CAUSE] <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     rx_count <= rx_count + 16'h0001;
                     if (gb_rx_eoi_in) begin
                        rx_status[ST_END_CAUSE] <= 1'b1;
                        state <= ST_IDLE;
                     end
                  end
               end
            end
            default: begin
               // Send states: load a byte when the output is empty, advance once taken.
               if (expired) begin
                  tx_status[ST_TIMEOUT] <= 1'b1;
                  gb_tx_valid_out <= 1'b0;
                  state <= ST_IDLE;
               end else if (tx_take) begin
                  gb_tx_valid_out <= 1'b0;
                  unique case (state)
                     ST_LSN: state <= ST_TLK;
                     ST_TLK: state <= (maxlen == 16'h0000) ? ST_TERM : ST_DATA;
                     ST_DATA: begin
                        tx_idx <= tx_idx + 16'h0001;
                        if (tx_idx + 16'h0001 == maxlen) begin
                           state <= ST_TERM;
                        end
                     end
                     ST_TERM: begin
                        term_idx <= 1'b1;
                        if (gb_tx_eoi_out) begin
                           state <= ST_IDLE;
                        end
                     end
                     default: state <= ST_IDLE;
                  endcase
               end else if (!gb_tx_valid_out) begin
                  gb_tx_valid_out <= 1'b1;
                  gb_tx_eoi_out <= 1'b0;
                  gb_tx_atn_out <= 1'b0;
                  unique case (state)
                     ST_LSN: begin
                        gb_tx_data_out <= LISTEN_BASE | {3'b000, tx_addr[4:0]};
                        gb_tx_atn_out <= 1'b1;
                     end
                     ST_TLK: begin
                        gb_tx_data_out <= TALK_BASE | {3'b000, own_addr};
                        gb_tx_atn_out <= 1'b1;
                     end
                     ST_DATA: gb_tx_data_out <= tx_byte;
                     ST_TERM: begin
                        gb_tx_data_out <= term_idx ? seq[15:8] : seq[7:0];
                        gb_tx_eoi_out <= term_idx || !seq[OUT_TWO_BIT];
                     end
                     default: gb_tx_valid_out <= 1'b0;
                  endcase
               end
            end
         endcase
      end
   end

   // Sticky completion events; a read clears only the bits it returned, so an event
   // landing on the clearing edge survives.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         int_status <= 2'h0;
      end else begin
         int_status <= (int_status & ~((acc_rd && paddr_in == OFF_INT_STATUS) ?
                        rd_latch[1:0] : 2'h0)) | {done_tx, done_rx};
      end
   end
   assign irq_out = |(int_status & int_mask);

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   property p_limit;
      (state == ST_RX) |-> (rx_count <= maxlen) && !(rx_count == maxlen && gb_rx_ready_out);
   endproperty
   a_limit: assert property (p_limit) else $error("receive passed limit");

   property p_not_listener;
      (state == ST_IDLE && start_rx && !listener_addressed_in) |=>
         (rx_status == 8'h02) && (state == ST_IDLE);
   endproperty
   a_not_listener: assert property (p_not_listener) else $error("listener check");

   property p_not_ctrl;
      (state == ST_IDLE && !start_rx && start_tx && !active_controller_in) |=>
         (tx_status == 8'h02) && (state == ST_IDLE);
   endproperty
   a_not_ctrl: assert property (p_not_ctrl) else $error("controller check");

   property p_bad_addr;
      (state == ST_IDLE && !start_rx && start_tx && active_controller_in &&
       tx_addr[4:0] == 5'h1F) |=> (tx_status == 8'h01);
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("address check");

   property p_eoi_end;
      (state == ST_RX && !expired && rx_take && gb_rx_eoi_in) |=>
         (state == ST_IDLE) && rx_status[5] && (rx_count == $past(rx_count) + 16'h0001 ||
         $past(term_hit));
   endproperty
   a_eoi_end: assert property (p_eoi_end) else $error("EOI end");

   property p_timeout;
      (state != ST_IDLE && expired) |=> (state == ST_IDLE) && (rx_status[3] || tx_status[3]);
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout end");

   property p_last_eoi;
      (gb_tx_valid_out && gb_tx_eoi_out) |-> (state == ST_TERM) && !gb_tx_atn_out;
   endproperty
   a_last_eoi: assert property (p_last_eoi) else $error("EOI outside terminator");

   property p_listen_cmd;
      (state == ST_LSN && gb_tx_valid_out) |-> gb_tx_atn_out &&
         gb_tx_data_out == (8'h20 | {3'b000, tx_addr[4:0]});
   endproperty
   a_listen_cmd: assert property (p_listen_cmd) else $error("listen command");

   property p_status_zero;
      (rx_status & 8'hD5) == 8'h00 && (tx_status & 8'hF4) == 8'h00;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("unused status bit");

   property p_mode_eoi;
      (state == ST_RX && eoi_only && rx_take && !gb_rx_eoi_in && !expired &&
       rx_count + 16'h0001 != maxlen) |=> (state == ST_RX);
   endproperty
   a_mode_eoi: assert property (p_mode_eoi) else $error("EOI mode ended early");
endmodule // gmt_message_transfer

// ===== hw/gmt_pkg.sv
// Package of constants, register map and state codes for the message transfer engine.
package gmt_pkg;
   // APB address width and register byte offsets.
   localparam int GMT_PAW = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_RX_TERM = 12'h004;
   localparam logic [11:0] OFF_TX_ADDR = 12'h008;
   localparam logic [11:0] OFF_MAXLEN = 12'h00C;
   localparam logic [11:0] OFF_RX_COUNT = 12'h010;
   localparam logic [11:0] OFF_RX_STATUS = 12'h014;
   localparam logic [11:0] OFF_TX_STATUS = 12'h018;
   localparam logic [11:0] OFF_IN_TERM = 12'h01C;
   localparam logic [11:0] OFF_OUT_TERM0 = 12'h020;
   localparam logic [11:0] OFF_OUT_TERM1 = 12'h024;
   localparam logic [11:0] OFF_OUT_TERM2 = 12'h028;
   localparam logic [11:0] OFF_OUT_TERM3 = 12'h02C;
   localparam logic [11:0] OFF_TIMEOUT = 12'h030;
   localparam logic [11:0] OFF_OWN_ADDR = 12'h034;
   localparam logic [11:0] OFF_INT_STATUS = 12'h038;
   localparam logic [11:0] OFF_INT_MASK = 12'h03C;
   // Storage window: word i of the data memory sits in page MEM_PAGE at byte offset 4*i.
   localparam logic [3:0] MEM_PAGE = 4'h1;
   // Control register bits.
   localparam int CTRL_START_RX = 0;
   localparam int CTRL_START_TX = 1;
   localparam int CTRL_EOI_ONLY = 2;
   // Receive terminator control byte fields.
   localparam int TERM_EN_BIT = 2;
   // Status bit positions.
   localparam int ST_BAD_ADDR = 0;
   localparam int ST_NOT_LISTENER = 1;
   localparam int ST_NOT_CONTROLLER = 1;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_END_CAUSE = 5;
   // Interrupt status bits.
   localparam int INT_RX_DONE = 0;
   localparam int INT_TX_DONE = 1;
   // Bus address limits and addressing command bases.
   localparam logic [4:0] ADDR_MAX = 5'h1E;
   localparam logic [7:0] LISTEN_BASE = 8'h20;
   localparam logic [7:0] TALK_BASE = 8'h40;
   // Reset contents of terminator storage: LF, CR, comma, semicolon.
   localparam logic [31:0] IN_TERM_RESET = 32'h3B2C0D0A;
   // Output sequences: bit 16 marks a two byte sequence, byte 0 goes first.
   localparam logic [16:0] OUT_TERM0_RESET = 17'h0000A;
   localparam logic [16:0] OUT_TERM1_RESET = 17'h10A0D;
   localparam logic [16:0] OUT_TERM2_RESET = 17'h0000D;
   localparam logic [16:0] OUT_TERM3_RESET = 17'h10D0A;
   localparam int OUT_TWO_BIT = 16;
   // Timeout interval and its cycle count at the 25 MHz clock.
   localparam int CLK_HZ = 25000000;
   localparam int TIMEOUT_US = 10000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1000000);
   // Engine states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_LSN = 3'b010,
      ST_TLK = 3'b011,
      ST_DATA = 3'b100,
      ST_TERM = 3'b101
   } gmt_state_t;
endpackage

// ===== verification/gmt_far_end.sv
// Far-end instrument model: a talker feeding bytes and a listener taking them.
`timescale 1ns/1ps
module gmt_far_end (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic rx_ready_in,
   input wire logic tx_valid_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_eoi_out,
   output logic tx_ready_out
);
   logic [8:0] rx_q[$]; // Bytes still to be offered, EOI in bit 8.
   logic block = 1'b0; // Set to hold off every byte offered by the engine.
   int seed = 23889;
   logic pace;
   // A byte stays offered until taken; an idle line inverts its data bits on every cycle.
   always @(posedge clock_in) begin
      pace = $random(seed);
      if (rx_valid_out && rx_ready_in) begin
         void'(rx_q.pop_front());
      end
      if (sys_rst_in) begin
         {rx_valid_out, rx_eoi_out} <= 2'h0;
         rx_data_out <= 8'h5A;
      end else if (!rx_valid_out || rx_ready_in) begin
         if (rx_q.size() > 0 && pace) begin
            rx_valid_out <= 1'b1;
            {rx_eoi_out, rx_data_out} <= rx_q[0];
         end else begin
            {rx_valid_out, rx_eoi_out} <= 2'h0;
            rx_data_out <= ~rx_data_out;
         end
      end
      // Random stalls make the engine hold its byte over several cycles; ready is only
      // offered once a byte stands, as a real listener would.
      tx_ready_out <= !block && tx_valid_in && ($random(seed) % 3 != 0);
   end
endmodule // gmt_far_end

// ===== verification/tb.sv
// Self-checking bench for the message transfer engine and its far-end model.
`timescale 1ns/1ps
module tb import gmt_pkg::*; ;
   logic clock_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic listener = 1'b0, controller = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, w;
   logic pready, pslverr, rxv, rxe, rxr, txv, txe, txa, txr, busy, irq;
   logic [7:0] rxd, txd, b;
   logic [16:0] ot[4];
   int n_fail = 0, n_compared = 0, cyc = 0, seed = 23889, n, a, sel;
   logic [32:0] rd_q[$]; // Expected {pslverr, prdata} of each pending read.
   logic [9:0] tx_q[$]; // Expected {atn, eoi, byte} of each byte sent.
   initial forever #20 clock_in = ~clock_in;
   // Short timeout and memory keep every scenario brief.
   gmt_message_transfer #(.DEPTH(16), .TIMEOUT_CYCLES(50)) i_dut (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .listener_addressed_in(listener),
      .active_controller_in(controller), .gb_rx_valid_in(rxv), .gb_rx_data_in(rxd),
      .gb_rx_eoi_in(rxe), .gb_rx_ready_out(rxr), .gb_tx_valid_out(txv),
      .gb_tx_data_out(txd), .gb_tx_eoi_out(txe), .gb_tx_atn_out(txa),
      .gb_tx_ready_in(txr), .busy_out(busy), .irq_out(irq));
   gmt_far_end i_far (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .rx_ready_in(rxr),
      .tx_valid_in(txv), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_eoi_out(rxe),
      .tx_ready_out(txr));
   task check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clock_in);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, d};
      @(posedge clock_in);
      penable <= 1'b1;
      do @(posedge clock_in); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [11:0] ad, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, ad, 32'h0);
   endtask
   task wait_idle;
      repeat (2) @(posedge clock_in);
      while (busy !== 1'b0) @(posedge clock_in);
   endtask
   task finish_test;
      $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watches read answers and sent bytes, oldest note first; also cuts a hang short.
   always @(posedge clock_in) begin
      if (psel && penable && !pwrite && pready)
         check({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 'x);
      if (txv && txr)
         check(33'({txa, txe, txd}), tx_q.size() ? 33'(tx_q.pop_front()) : 'x);
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      ot = '{17'h00021, OUT_TERM1_RESET, OUT_TERM2_RESET, OUT_TERM3_RESET};
      repeat (5) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(OFF_IN_TERM, {1'b0, IN_TERM_RESET});
      rd(OFF_OUT_TERM3, {16'h0, OUT_TERM3_RESET});
      rd(OFF_TIMEOUT, 33'h32);
      rd(OFF_RX_STATUS, 33'h0);
      rd(12'h0FC, {1'b1, 32'h0});
      apb(1'b1, OFF_INT_MASK, 32'h3);
      apb(1'b1, OFF_MAXLEN, 32'h20);
      listener <= 1'b1;
      for (sel = 0; sel < 4; sel++) begin
         n = 4 + $unsigned($random(seed)) % 3;
         for (int i = 0; i < n; i++) begin
            b = 8'h41 + 8'($unsigned($random(seed)) % 26);
            if (i < 4) w[8*i+:8] = b;
            i_far.rx_q.push_back({1'b0, b});
         end
         i_far.rx_q.push_back({1'b0, IN_TERM_RESET[8*sel+:8]});
         apb(1'b1, OFF_RX_TERM, {29'h0, 1'b1, 2'(sel)});
         apb(1'b1, OFF_CTRL, 32'h1);
         wait_idle;
         @(negedge clock_in) check({32'h0, irq}, 33'h1);
         rd(OFF_RX_COUNT, 33'(n));
         rd(OFF_RX_STATUS, 33'h20);
         rd({MEM_PAGE, 8'h00}, {1'b0, w});
         rd(OFF_INT_STATUS, 33'h1);
      end
      @(negedge clock_in) check({32'h0, irq}, 33'h0);
      // Terminator off, then EOI-only mode with a terminator enabled: all four bytes stay data.
      apb(1'b1, OFF_INT_MASK, 32'h0);
      for (sel = 0; sel < 2; sel++) begin
         for (int i = 0; i < 4; i++) i_far.rx_q.push_back({i == 3, IN_TERM_RESET[8*i+:8]});
         apb(1'b1, OFF_RX_TERM, 32'(4 * sel));
         apb(1'b1, OFF_CTRL, 32'(1 + 4 * sel));
         wait_idle;
         @(negedge clock_in) check({32'h0, irq}, 33'h0);
         rd(OFF_RX_COUNT, 33'h4);
         rd(OFF_RX_STATUS, 33'h20);
         rd({MEM_PAGE, 8'h00}, {1'b0, IN_TERM_RESET});
      end
      // The mode bit reads back set and the busy bit clear once reception is over.
      rd(OFF_CTRL, 33'h4);
      rd(OFF_INT_STATUS, 33'h1);
      apb(1'b1, OFF_INT_MASK, 32'h3);
      // Limit of three with four bytes offered; the fourth opens the timed-out receive.
      apb(1'b1, OFF_MAXLEN, 32'h3);
      apb(1'b1, OFF_RX_TERM, 32'h0);
      for (int i = 0; i < 4; i++) begin
         w[8*i+:8] = 8'($random(seed));
         i_far.rx_q.push_back({1'b0, w[8*i+:8]});
      end
      apb(1'b1, OFF_CTRL, 32'h1);
      wait_idle;
      rd(OFF_RX_COUNT, 33'h3);
      rd(OFF_RX_STATUS, 33'h0);
      apb(1'b1, OFF_MAXLEN, 32'h8);
      apb(1'b1, OFF_CTRL, 32'h1);
      wait_idle;
      rd(OFF_RX_COUNT, 33'h1);
      rd(OFF_RX_STATUS, 33'h8);
      rd({MEM_PAGE, 8'h00}, {9'h03B, w[23:8], w[31:24]});
      listener <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h1);
      wait_idle;
      rd(OFF_RX_STATUS, 33'h2);
      controller <= 1'b1;
      w = $random(seed);
      apb(1'b1, {MEM_PAGE, 8'h00}, w);
      apb(1'b1, OFF_OWN_ADDR, 32'h5);
      apb(1'b1, OFF_MAXLEN, 32'h2);
      apb(1'b1, OFF_OUT_TERM0, 32'h21);
      for (sel = 0; sel < 4; sel++) begin
         a = $unsigned($random(seed)) % 31;
         tx_q.push_back({2'b10, LISTEN_BASE | 8'(a)});
         tx_q.push_back({2'b10, TALK_BASE | 8'h05});
         tx_q.push_back({2'b00, w[7:0]});
         tx_q.push_back({2'b00, w[15:8]});
         if (ot[sel][OUT_TWO_BIT]) tx_q.push_back({2'b00, ot[sel][7:0]});
         tx_q.push_back({2'b01, ot[sel][OUT_TWO_BIT] ? ot[sel][15:8] : ot[sel][7:0]});
         apb(1'b1, OFF_TX_ADDR, {24'h0, 2'(sel), 1'b0, 5'(a)});
         apb(1'b1, OFF_CTRL, 32'h2);
         wait_idle;
         rd(OFF_TX_STATUS, 33'h0);
         check(33'(tx_q.size()), 33'h0);
      end
      for (sel = 0; sel < 2; sel++) begin
         apb(1'b1, OFF_TX_ADDR, sel ? 32'h23 : 32'h1F);
         apb(1'b1, OFF_CTRL, 32'h2);
         wait_idle;
         rd(OFF_TX_STATUS, 33'h1);
      end
      i_far.block <= 1'b1;
      apb(1'b1, OFF_TX_ADDR, 32'h3);
      apb(1'b1, OFF_CTRL, 32'h2);
      // The stalled send keeps the engine busy until the watchdog gives up.
      @(negedge clock_in) check({32'h0, busy}, 33'h1);
      wait_idle;
      rd(OFF_TX_STATUS, 33'h8);
      i_far.block <= 1'b0;
      controller <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h2);
      wait_idle;
      rd(OFF_TX_STATUS, 33'h2);
      finish_test;
   end
endmodule // tb
